// ### rtl/ccrg_pkg.sv
// types shared by the clock channel and generator register logic
package ccrg_pkg;

  // one register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic wr;
    logic rd;
  } ccrg_bus_req_t;

  // per-channel control state
  typedef struct packed {
    logic lock;
    logic en;
    logic [3:0] gen;
  } ccrg_chan_t;

  // per-generator stored configuration
  typedef struct packed {
    logic [5:0] flags;
    logic [4:0] src;
  } ccrg_gen_cfg_t;

  // kind of write waiting for synchronization
  typedef enum logic [1:0] {
    CCRG_PEND_NONE = 2'b00,
    CCRG_PEND_CHAN = 2'b01,
    CCRG_PEND_GEN = 2'b10,
    CCRG_PEND_SWRST = 2'b11
  } ccrg_pend_t;

  // synchronizer states
  typedef enum logic {
    CCRG_SYNC_IDLE = 1'b0,
    CCRG_SYNC_BUSY = 1'b1
  } ccrg_sync_state_t;

endpackage

// ### rtl/ccrg_regs.svh
// register offsets, field positions, reset values and timing counts of the clock unit
`ifndef CCRG_REGS_SVH
`define CCRG_REGS_SVH

// register offsets (byte addresses on the plain register port)
`define CCRG_ADDR_CTRL 4'h0
`define CCRG_ADDR_STATUS 4'h1
`define CCRG_ADDR_CHAN 4'h2
`define CCRG_ADDR_GEN 4'h4

// control and status bit positions
`define CCRG_CTRL_SWRST_BIT 0
`define CCRG_STATUS_BUSY_BIT 7

// clock_channel_control field positions
`define CCRG_CHAN_ID_LSB 0
`define CCRG_CHAN_GEN_LSB 8
`define CCRG_CHAN_EN_BIT 14
`define CCRG_CHAN_LOCK_BIT 15

// generator_config field positions
`define CCRG_GEN_ID_LSB 0
`define CCRG_GEN_SRC_LSB 8
`define CCRG_GEN_FLAGS_LSB 16

// sizes
`define CCRG_NUM_CHAN 20
`define CCRG_NUM_GEN 9

// channel selection codes
`define CCRG_CHAN_WDT 6'h03
`define CCRG_CHAN_RTC 6'h04
`define CCRG_CHAN_RSV_A 6'h06
`define CCRG_CHAN_RSV_B 6'h10
`define CCRG_CHAN_RSV_C 6'h11
`define CCRG_CHAN_TIMER2 6'h12
`define CCRG_CHAN_CONV 6'h13

// reset values
`define CCRG_WDT_GEN_RESET 4'h2
`define CCRG_GEN_SEL_RESET 4'h0
`define CCRG_GEN_SRC_RESET 5'h00
`define CCRG_GEN_FLAGS_RESET 6'h00
`define CCRG_UNLOCKABLE_GEN 4'h0

// byte enable patterns
`define CCRG_BE_LOW_BYTE 4'h1
`define CCRG_BE_HALF 4'h3
`define CCRG_BE_WORD 4'hF

// cycles a synchronized write spends crossing before it takes effect
`define CCRG_SYNC_CYCLES 3'h4

`endif

// ### rtl/ccrg_sync.sv
// write synchronization timer: holds busy while a write crosses and pulses done in its last busy cycle
`timescale 1ns/1ps
`include "ccrg_regs.svh"

module ccrg_sync import ccrg_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);

  ccrg_sync_state_t state_reg;
  logic [2:0] cnt_reg;

  //////////////////////////////////////////////////////////////////////////////
  // state: start is only honoured while idle, the caller refuses writes when busy
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= CCRG_SYNC_IDLE;
    end else begin
      case (state_reg)
        CCRG_SYNC_IDLE: begin
          if (start) begin
            state_reg <= CCRG_SYNC_BUSY;
          end
        end
        CCRG_SYNC_BUSY: begin
          if (done) begin
            state_reg <= CCRG_SYNC_IDLE;
          end
        end
        default: state_reg <= CCRG_SYNC_IDLE;
      endcase
    end
  end

  // cycle counter of the crossing
  always_ff @(posedge sys_clk) begin
    if (srst || state_reg == CCRG_SYNC_IDLE) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  // busy follows the state register, done also decodes the cycle counter
  assign busy = (state_reg == CCRG_SYNC_BUSY);
  assign done = busy && (cnt_reg == `CCRG_SYNC_CYCLES - 3'h1);

endmodule // ccrg_sync

// ### rtl/ccrg_top.sv
// clock channel control and generator configuration registers with reset handling
`timescale 1ns/1ps
`include "ccrg_regs.svh"

module ccrg_top import ccrg_pkg::*; (
  // clock and power reset
  input wire logic sys_clk,
  input wire logic srst,
  // register port
  input wire ccrg_bus_req_t bus_req,
  output logic [31:0] rd_data,
  // asynchronous user reset and nonvolatile straps
  input wire logic user_reset,
  input wire logic nvm_wdt_enable,
  input wire logic nvm_wdt_always_on,
  // clock tree controls
  output logic [`CCRG_NUM_CHAN-1:0] chan_enable,
  output logic [`CCRG_NUM_CHAN*4-1:0] chan_gen_select,
  output logic [`CCRG_NUM_GEN-1:0] gen_enable
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // true when a selection code names an implemented channel
  function automatic logic chan_valid(input logic [5:0] id);
    chan_valid = (id < 6'(`CCRG_NUM_CHAN)) && (id != `CCRG_CHAN_RSV_A) &&
                 (id != `CCRG_CHAN_RSV_B) && (id != `CCRG_CHAN_RSV_C);
  endfunction

  // true when an index names an implemented generator
  function automatic logic gen_valid(input logic [3:0] id);
    gen_valid = (id < 4'(`CCRG_NUM_GEN));
  endfunction

  // in-range array index for a channel code; unmapped codes fall on 0 and are masked
  function automatic logic [4:0] chan_slot(input logic [5:0] id);
    chan_slot = chan_valid(id) ? id[4:0] : 5'h00;
  endfunction

  // in-range array index for a generator
  function automatic logic [3:0] gen_slot(input logic [3:0] id);
    gen_slot = gen_valid(id) ? id : 4'h0;
  endfunction

  // power-on value of one channel
  function automatic ccrg_chan_t chan_power(input logic [5:0] id, input logic wdt_en,
                                            input logic wdt_lock);
    ccrg_chan_t c;
    c.gen = `CCRG_GEN_SEL_RESET;
    c.en = 1'b0;
    c.lock = 1'b0;
    if (id == `CCRG_CHAN_WDT) begin
      c.gen = `CCRG_WDT_GEN_RESET;
      c.en = wdt_en;
      c.lock = wdt_lock;
    end
    chan_power = c;
  endfunction

  // value of one channel after a user reset; the lock bit is always carried over
  function automatic ccrg_chan_t chan_user(input ccrg_chan_t cur, input logic [5:0] id,
                                           input logic wdt_en);
    ccrg_chan_t c;
    c = cur;
    if (id == `CCRG_CHAN_RTC) begin
      if (!cur.lock && !cur.en) begin
        c.gen = `CCRG_GEN_SEL_RESET;
        c.en = 1'b0;
      end
    end else if (!cur.lock) begin
      if (id == `CCRG_CHAN_WDT) begin
        c.gen = `CCRG_WDT_GEN_RESET;
        c.en = wdt_en;
      end else begin
        c.gen = `CCRG_GEN_SEL_RESET;
        c.en = 1'b0;
      end
    end
    chan_user = c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // storage and control

  ccrg_chan_t chan_reg [`CCRG_NUM_CHAN];
  ccrg_gen_cfg_t gen_reg [`CCRG_NUM_GEN];
  logic [5:0] chan_idx_reg;
  logic [3:0] gen_idx_reg;
  ccrg_pend_t pend_kind_reg;
  logic [31:0] pend_data_reg;
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic user_rst_sync;
  logic wdt_en_sync;
  logic wdt_lock_sync;
  logic sync_busy;
  logic sync_done;
  logic sync_start;
  logic user_rst_now;
  logic [`CCRG_NUM_GEN-1:0] gen_lock_vec;
  logic wr_ctrl;
  logic wr_chan;
  logic wr_gen;
  logic chan_full;
  logic gen_full;
  logic idx_only;
  logic [5:0] wr_chan_id;
  logic [3:0] wr_gen_id;
  logic [5:0] pend_chan_id;
  logic [3:0] pend_gen_id;
  logic start_chan;
  logic start_gen;
  logic start_swrst;
  ccrg_chan_t rd_chan;
  ccrg_gen_cfg_t rd_gen;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronizers: user reset and straps come from outside this clock
  // no reset here so the straps are already settled while srst is held
  always_ff @(posedge sys_clk) begin
    pin_meta_reg <= {user_reset, nvm_wdt_enable, nvm_wdt_always_on};
    pin_sync_reg <= pin_meta_reg;
  end

  assign user_rst_sync = pin_sync_reg[2];
  assign wdt_en_sync = pin_sync_reg[1];
  assign wdt_lock_sync = pin_sync_reg[0];

  //////////////////////////////////////////////////////////////////////////////
  // generators guarded by a locked channel; generator 0 is never guarded
  always_comb begin
    gen_lock_vec = '0;
    for (int i = 0; i < `CCRG_NUM_CHAN; i++) begin
      if (chan_reg[i].lock && gen_valid(chan_reg[i].gen) &&
          chan_reg[i].gen != `CCRG_UNLOCKABLE_GEN) begin
        gen_lock_vec[gen_slot(chan_reg[i].gen)] = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write decode
  assign wr_ctrl = bus_req.wr && (bus_req.addr == `CCRG_ADDR_CTRL);
  assign wr_chan = bus_req.wr && (bus_req.addr == `CCRG_ADDR_CHAN);
  assign wr_gen = bus_req.wr && (bus_req.addr == `CCRG_ADDR_GEN);
  assign chan_full = (bus_req.be == `CCRG_BE_HALF) || (bus_req.be == `CCRG_BE_WORD);
  assign gen_full = (bus_req.be == `CCRG_BE_WORD);
  assign idx_only = (bus_req.be == `CCRG_BE_LOW_BYTE);
  assign wr_chan_id = bus_req.wdata[`CCRG_CHAN_ID_LSB +: 6];
  assign wr_gen_id = bus_req.wdata[`CCRG_GEN_ID_LSB +: 4];

  // a synchronized write is accepted only when nothing is crossing and no reset runs;
  // a refused write is dropped silently, software polls the status busy bit first
  assign start_chan = wr_chan && chan_full && !sync_busy && !user_rst_sync &&
                      chan_valid(wr_chan_id) && !chan_reg[chan_slot(wr_chan_id)].lock;
  assign start_gen = wr_gen && gen_full && !sync_busy && !user_rst_sync &&
                     gen_valid(wr_gen_id) && !gen_lock_vec[gen_slot(wr_gen_id)];
  assign start_swrst = wr_ctrl && bus_req.be[0] && bus_req.wdata[`CCRG_CTRL_SWRST_BIT] &&
                       !sync_busy && !user_rst_sync;
  assign sync_start = start_chan || start_gen || start_swrst;

  // write synchronization timer
  ccrg_sync u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(sync_start),
    .busy(sync_busy),
    .done(sync_done)
  );

  // a software reset acts like a user reset once its crossing completes
  assign user_rst_now = user_rst_sync || (sync_done && pend_kind_reg == CCRG_PEND_SWRST);

  //////////////////////////////////////////////////////////////////////////////
  // pending write capture, released by the synchronizer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pend_kind_reg <= CCRG_PEND_NONE;
      pend_data_reg <= 32'h0000_0000;
    end else if (sync_start) begin
      pend_data_reg <= bus_req.wdata;
      if (start_chan) begin
        pend_kind_reg <= CCRG_PEND_CHAN;
      end else if (start_gen) begin
        pend_kind_reg <= CCRG_PEND_GEN;
      end else begin
        pend_kind_reg <= CCRG_PEND_SWRST;
      end
    end else if (sync_done) begin
      pend_kind_reg <= CCRG_PEND_NONE;
    end
  end

  assign pend_chan_id = pend_data_reg[`CCRG_CHAN_ID_LSB +: 6];
  assign pend_gen_id = pend_data_reg[`CCRG_GEN_ID_LSB +: 4];

  //////////////////////////////////////////////////////////////////////////////
  // read-back selections; an index-only write moves them and nothing else
  always_ff @(posedge sys_clk) begin
    if (srst || user_rst_now) begin
      chan_idx_reg <= 6'h00;
    end else if (wr_chan && (idx_only || chan_full)) begin
      chan_idx_reg <= wr_chan_id;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || user_rst_now) begin
      gen_idx_reg <= 4'h0;
    end else if (wr_gen && (idx_only || gen_full)) begin
      gen_idx_reg <= wr_gen_id;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channel control state
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < `CCRG_NUM_CHAN; i++) begin
      if (srst) begin
        chan_reg[i] <= chan_power(6'(i), wdt_en_sync, wdt_lock_sync);
      end else if (user_rst_now) begin
        chan_reg[i] <= chan_user(chan_reg[i], 6'(i), wdt_en_sync);
      end else if (sync_done && pend_kind_reg == CCRG_PEND_CHAN &&
                   pend_chan_id == 6'(i)) begin
        chan_reg[i].gen <= pend_data_reg[`CCRG_CHAN_GEN_LSB +: 4];
        chan_reg[i].en <= pend_data_reg[`CCRG_CHAN_EN_BIT];
        // writing zero never releases a lock
        chan_reg[i].lock <= chan_reg[i].lock || pend_data_reg[`CCRG_CHAN_LOCK_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // generator configuration; only bits 12:8 and 21:16 are stored, the rest never exists
  always_ff @(posedge sys_clk) begin
    for (int g = 0; g < `CCRG_NUM_GEN; g++) begin
      if (srst) begin
        gen_reg[g].flags <= `CCRG_GEN_FLAGS_RESET;
        gen_reg[g].src <= `CCRG_GEN_SRC_RESET;
      end else if (sync_done && pend_kind_reg == CCRG_PEND_GEN &&
                   pend_gen_id == 4'(g)) begin
        gen_reg[g].flags <= pend_data_reg[`CCRG_GEN_FLAGS_LSB +: 6];
        gen_reg[g].src <= pend_data_reg[`CCRG_GEN_SRC_LSB +: 5];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path: data stand one cycle after the read strobe
  always_comb begin
    rd_chan = chan_reg[chan_slot(chan_idx_reg)];
    if (!chan_valid(chan_idx_reg)) begin
      rd_chan = '0;
    end
    rd_gen = gen_reg[gen_slot(gen_idx_reg)];
    if (!gen_valid(gen_idx_reg)) begin
      rd_gen = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_data <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      rd_data <= 32'h0000_0000;
      case (bus_req.addr)
        `CCRG_ADDR_CTRL: begin
          rd_data[`CCRG_CTRL_SWRST_BIT] <= (pend_kind_reg == CCRG_PEND_SWRST);
        end
        `CCRG_ADDR_STATUS: begin
          rd_data[`CCRG_STATUS_BUSY_BIT] <= sync_busy;
        end
        `CCRG_ADDR_CHAN: begin
          rd_data[`CCRG_CHAN_ID_LSB +: 6] <= chan_idx_reg;
          rd_data[`CCRG_CHAN_GEN_LSB +: 4] <= rd_chan.gen;
          rd_data[`CCRG_CHAN_EN_BIT] <= rd_chan.en;
          rd_data[`CCRG_CHAN_LOCK_BIT] <= rd_chan.lock;
        end
        `CCRG_ADDR_GEN: begin
          // bits 31:22 and the reserved holes stay zero
          rd_data[`CCRG_GEN_ID_LSB +: 4] <= gen_idx_reg;
          rd_data[`CCRG_GEN_SRC_LSB +: 5] <= rd_gen.src;
          rd_data[`CCRG_GEN_FLAGS_LSB +: 6] <= rd_gen.flags;
        end
        default: rd_data <= 32'h0000_0000;
      endcase
    end else begin
      rd_data <= 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock tree controls straight from the stored state
  always_comb begin
    for (int i = 0; i < `CCRG_NUM_CHAN; i++) begin
      chan_enable[i] = chan_reg[i].en;
      chan_gen_select[i*4 +: 4] = chan_reg[i].gen;
    end
    for (int g = 0; g < `CCRG_NUM_GEN; g++) begin
      gen_enable[g] = gen_reg[g].flags[0];
    end
  end

endmodule // ccrg_top

// ### tb/ccrg_checker.sv
// port-level assertions for the clock channel and generator register block
`timescale 1ns/1ps
`include "ccrg_regs.svh"

module ccrg_checker import ccrg_pkg::*; (
  // clock and power reset
  input wire logic sys_clk,
  input wire logic srst,
  // register port
  input wire ccrg_bus_req_t bus_req,
  input wire logic [31:0] rd_data,
  // user reset and straps
  input wire logic user_reset,
  input wire logic nvm_wdt_enable,
  input wire logic nvm_wdt_always_on,
  // clock tree controls
  input wire logic [`CCRG_NUM_CHAN-1:0] chan_enable,
  input wire logic [`CCRG_NUM_CHAN*4-1:0] chan_gen_select,
  input wire logic [`CCRG_NUM_GEN-1:0] gen_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////
  // power reset long enough for the straps to cross two flops
  sequence s_power_held;
    (srst && $stable(nvm_wdt_enable) && $stable(nvm_wdt_always_on)) [*4];
  endsequence
  // user reset held until any write in flight has drained
  sequence s_user_held;
    user_reset [*6];
  endsequence
  // index-only select of a generator, then its read
  sequence s_gen_select_read;
    (bus_req.wr && bus_req.be == `CCRG_BE_LOW_BYTE && bus_req.addr == `CCRG_ADDR_GEN)
      ##1 (bus_req.rd && bus_req.addr == `CCRG_ADDR_GEN);
  endsequence

  ////////////////////////////////////////////////////////////
  // power reset checks must run while srst is high, so they bypass the default disable
  a_power_wdt_init: assert property (disable iff (1'b0) s_power_held |=>
    chan_enable[3] == $past(nvm_wdt_enable) && chan_gen_select[15:12] == 4'h2)
    else $error("watchdog channel wrong after power reset");
  a_power_all_zero: assert property (disable iff (1'b0) s_power_held |=>
    (chan_enable & 20'hFFFF7) == 20'h0 && (chan_gen_select & ~80'hF000) == 80'h0
    && gen_enable == 9'h0) else $error("channel not cleared by power reset");
  a_read_idle_zero: assert property (!$past(bus_req.rd) |-> rd_data == 32'h0)
    else $error("read data outside its cycle");
  a_gen_rsvd_zero: assert property ($past(bus_req.rd) && $past(bus_req.addr) ==
    `CCRG_ADDR_GEN |-> rd_data[31:22] == 10'h0) else $error("generator top bits not zero");
  a_gen_index_echo: assert property (s_gen_select_read |=>
    rd_data[3:0] == $past(bus_req.wdata[3:0], 2)) else $error("generator read index wrong");
  a_user_rtc_kept: assert property (s_user_held ##0 chan_enable[4] |=> chan_enable[4])
    else $error("enabled rtc channel cleared by user reset");
  a_user_wdt_gen: assert property (user_reset [*4] |->
    chan_gen_select[15:12] == 4'h2 || $stable(chan_gen_select[15:12]))
    else $error("watchdog select wrong under user reset");
  a_user_no_rise: assert property (s_user_held |=>
    (chan_enable & ~$past(chan_enable) & 20'hFFFF7) == 20'h0)
    else $error("channel enabled by user reset");
endmodule // ccrg_checker

bind ccrg_top ccrg_checker ccrg_checker_u (.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req),
  .rd_data(rd_data), .user_reset(user_reset), .nvm_wdt_enable(nvm_wdt_enable),
  .nvm_wdt_always_on(nvm_wdt_always_on), .chan_enable(chan_enable),
  .chan_gen_select(chan_gen_select), .gen_enable(gen_enable));

// ### tb/tb_ccrg_top.sv
// self-checking bench for the clock channel and generator register block
`timescale 1ns/1ps
`include "ccrg_regs.svh"

module tb_ccrg_top import ccrg_pkg::*; ;
  logic sys_clk, srst, user_reset, nvm_wdt_enable, nvm_wdt_always_on;
  ccrg_bus_req_t bus_req;
  logic [31:0] rd_data;
  logic [19:0] chan_enable, exp_en;
  logic [79:0] chan_gen_select, exp_gs;
  logic [8:0] gen_enable, exp_gen;
  int num_errors, samples_checked, cycles;
  logic [5:0] rsv [4] = '{6'h10, 6'h11, 6'h14, 6'h3F};

  ccrg_top dut_u (.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
    .user_reset(user_reset), .nvm_wdt_enable(nvm_wdt_enable),
    .nvm_wdt_always_on(nvm_wdt_always_on), .chan_enable(chan_enable),
    .chan_gen_select(chan_gen_select), .gen_enable(gen_enable));

  // 25 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////
  task test_done;
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // a hang is cut short well past the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      test_done();
    end
  end

  task chk(input logic [79:0] got, input logic [79:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task cmp_out;
    #1;
    chk(chan_enable, exp_en);
    chk(chan_gen_select, exp_gs);
    chk(gen_enable, exp_gen);
  endtask

  // one strobe cycle, launched just after an edge
  task put(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b, input logic w, r);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, be: b, wr: w, rd: r};
  endtask
  task idle;
    @(posedge sys_clk);
    bus_req <= '0;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    put(a, d, b, 1'b1, 1'b0);
    idle();
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [31:0] exp);
    put(a, 32'h0, 4'h0, 1'b0, 1'b1);
    idle();
    #1 chk(rd_data, exp);
  endtask
  // index byte write and read back to back
  task sel_rd(input logic [3:0] a, input logic [5:0] id, input logic [31:0] exp);
    put(a, {26'h0, id}, `CCRG_BE_LOW_BYTE, 1'b1, 1'b0);
    rd(a, exp);
  endtask
  // busy must show right after an accepted write, then drop
  task sync_wait;
    int i;
    rd(`CCRG_ADDR_STATUS, 32'h80);
    for (i = 0; i < 8 && rd_data[7] === 1'b1; i++) begin
      put(`CCRG_ADDR_STATUS, 32'h0, 4'h0, 1'b0, 1'b1);
      idle();
      #1;
    end
    rd(`CCRG_ADDR_STATUS, 32'h0);
  endtask
  // refused writes may not start a crossing, so wait a fixed span
  task wchan(input logic [5:0] id, input logic [3:0] g, input logic en, lk, ok);
    wr(`CCRG_ADDR_CHAN, {16'h0, lk, en, 2'h0, g, 2'h0, id}, `CCRG_BE_HALF);
    if (ok) sync_wait();
    else repeat (6) @(posedge sys_clk);
  endtask
  task ureset;
    @(posedge sys_clk);
    user_reset <= 1'b1;
    repeat (8) @(posedge sys_clk);
    user_reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    user_reset = 1'b0;
    nvm_wdt_enable = 1'b1;
    nvm_wdt_always_on = 1'b0;
    bus_req = '0;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    exp_en = 20'h8;
    exp_gs = 80'h2000;
    exp_gen = 9'h0;
    cmp_out();
    sel_rd(`CCRG_ADDR_GEN, 6'h0, 32'h0);
    rd(4'h8, 32'h0);
    // the two last mapped codes, then two reserved and two out-of-range codes
    wchan(6'h12, 4'h5, 1'b1, 1'b0, 1'b1);
    wchan(6'h13, 4'h6, 1'b1, 1'b0, 1'b1);
    exp_en[19:18] = 2'h3;
    exp_gs[79:72] = 8'h65;
    cmp_out();
    foreach (rsv[k]) begin
      wchan(rsv[k], 4'h7, 1'b1, 1'b0, 1'b0);
      cmp_out();
      sel_rd(`CCRG_ADDR_CHAN, rsv[k], {26'h0, rsv[k]});
    end
    // full generator writes, index boundary and out-of-range index
    wr(`CCRG_ADDR_GEN, 32'h00010603, `CCRG_BE_WORD);
    sync_wait();
    wr(`CCRG_ADDR_GEN, 32'h003F1F08, `CCRG_BE_WORD);
    sync_wait();
    exp_gen = 9'h108;
    cmp_out();
    sel_rd(`CCRG_ADDR_GEN, 6'h3, 32'h00010603);
    wr(`CCRG_ADDR_GEN, 32'h00000005, `CCRG_BE_LOW_BYTE);
    rd(`CCRG_ADDR_GEN, 32'h5);
    sel_rd(`CCRG_ADDR_GEN, 6'h8, 32'h003F1F08);
    wr(`CCRG_ADDR_GEN, 32'h00010609, `CCRG_BE_WORD);
    repeat (6) @(posedge sys_clk);
    cmp_out();
    sel_rd(`CCRG_ADDR_GEN, 6'h9, 32'h9);
    // lock holds channel and its generator; generator 0 stays writable
    wchan(6'h05, 4'h3, 1'b1, 1'b1, 1'b1);
    wchan(6'h05, 4'h0, 1'b0, 1'b0, 1'b0);
    wr(`CCRG_ADDR_GEN, 32'h00000003, `CCRG_BE_WORD);
    repeat (6) @(posedge sys_clk);
    exp_en[5] = 1'b1;
    exp_gs[23:20] = 4'h3;
    cmp_out();
    sel_rd(`CCRG_ADDR_CHAN, 6'h05, 32'h0000C305);
    wchan(6'h07, 4'h0, 1'b1, 1'b1, 1'b1);
    wr(`CCRG_ADDR_GEN, 32'h00010000, `CCRG_BE_WORD);
    sync_wait();
    exp_en[7] = 1'b1;
    exp_gen[0] = 1'b1;
    cmp_out();
    // user reset with rtc enabled and watchdog unlocked
    wchan(6'h04, 4'h1, 1'b1, 1'b0, 1'b1);
    wchan(6'h03, 4'h4, 1'b0, 1'b0, 1'b1);
    ureset();
    exp_en[4] = 1'b1;
    exp_en[19:18] = 2'h0;
    exp_gs[79:72] = 8'h0;
    exp_gs[19:16] = 4'h1;
    cmp_out();
    sel_rd(`CCRG_ADDR_CHAN, 6'h05, 32'h0000C305);
    // rtc idle and unlocked is cleared; a locked watchdog keeps its settings
    wchan(6'h04, 4'h6, 1'b0, 1'b0, 1'b1);
    wchan(6'h03, 4'h5, 1'b1, 1'b1, 1'b1);
    @(posedge sys_clk);
    nvm_wdt_enable <= 1'b0;
    ureset();
    exp_en[4] = 1'b0;
    exp_gs[19:12] = 8'h05;
    cmp_out();
    // software reset acts as a user reset once its crossing completes
    wchan(6'h09, 4'h2, 1'b1, 1'b0, 1'b1);
    exp_en[9] = 1'b1;
    exp_gs[39:36] = 4'h2;
    cmp_out();
    wr(`CCRG_ADDR_CTRL, 32'h0000_0001, 4'h1);
    rd(`CCRG_ADDR_CTRL, 32'h0000_0001);
    sync_wait();
    exp_en[9] = 1'b0;
    exp_gs[39:36] = 4'h0;
    cmp_out();
    rd(`CCRG_ADDR_CTRL, 32'h0);
    // power reset clears locked channels too and reloads the straps
    @(posedge sys_clk);
    nvm_wdt_always_on <= 1'b1;
    srst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    exp_en = 20'h0;
    exp_gs = 80'h2000;
    exp_gen = 9'h0;
    cmp_out();
    sel_rd(`CCRG_ADDR_CHAN, 6'h03, 32'h00008203);
    test_done();
  end
endmodule // tb_ccrg_top
